/* File: rtl/emasr_pkg.sv */
// package: register map, field layout and types of the meter register bank
package emasr_pkg;
  // register byte offsets
  localparam logic [7:0] ALERT_EN_OFF  = 8'h1A;
  localparam logic [7:0] ENERGY_OFF    = 8'h7A;
  localparam logic [7:0] TICK_OFF      = 8'h80;
  localparam logic [7:0] METER_CTL_OFF = 8'h84;
  localparam logic [7:0] SNAP_CTL_OFF  = 8'h85;
  localparam logic [7:0] ENERGY_BYTES  = 8'h06;
  localparam logic [7:0] TICK_BYTES    = 8'h04;
  // widths
  localparam int ENERGY_W = 48;
  localparam int TICK_W   = 32;
  localparam int POWER_W  = 24;
  localparam int SNAP_W   = 16;
  // meter control field positions
  localparam int MC_RESET_BIT  = 7;
  localparam int MC_HALT_BIT   = 6;
  localparam int MC_TOVF_BIT   = 5;
  localparam int MC_EOVF_BIT   = 4;
  localparam int MC_ALERT_BIT  = 3;
  localparam int MC_LOCK_BIT   = 2;
  // snapshot control field positions
  localparam int SC_SEL_LSB    = 4;
  localparam int SC_HALT_BIT   = 3;
  // values after reset
  localparam logic [7:0]          ALERT_EN_RST = 8'h00;
  localparam logic [ENERGY_W-1:0] ENERGY_RST   = 48'h0000_0000_0000;
  localparam logic [TICK_W-1:0]   TICK_RST     = 32'h0000_0000;
  localparam logic [3:0]          SNAP_SEL_RST = 4'h0;
  // serial target address, value arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // serial engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_RACK = 5'b10000
  } emasr_st_t;

  // true when addr falls inside a multi-byte register
  function automatic logic in_span(input logic [7:0] a,
                                   input logic [7:0] base,
                                   input logic [7:0] n);
    return (a >= base) && (a < 8'(base + n));
  endfunction
endpackage

/* File: rtl/emasr_reg_if.sv */
// interface: byte register access from the serial engine to the bank
`timescale 1ns/100ps
`default_nettype none
interface emasr_reg_if;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus  (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: rtl/emasr_serial.sv */
// two-wire serial target: address, pointer byte, auto-increment data
`timescale 1ns/100ps
`default_nettype none
module emasr_serial (
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       sda_oe_n_o,
  emasr_reg_if.bus   regs
);
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  emasr_pkg::emasr_st_t st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wdat_q, wdat_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic       rnw_q, rnw_d, nack_q, nack_d, drv_q, drv_d, wr_q, wr_d;
  logic       start, stop, rise, fall, load;
  logic       oe_n_q, oe_n_d;

  // two-stage synchronisers; third stage only feeds edge detection
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
    end
  end

  assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign rise  = scl_s_q & ~scl_p_q;
  assign fall  = ~scl_s_q & scl_p_q;

  // byte engine; data changes only on scl fall to keep start/stop clean
  always_comb begin
    st_d = st_q; sh_d = sh_q; ptr_d = ptr_q; wdat_d = wdat_q;
    bit_d = bit_q; byte_d = byte_q; rnw_d = rnw_q; nack_d = nack_q;
    drv_d = drv_q; wr_d = 1'b0; load = 1'b0;
    if (wr_q) ptr_d = ptr_q + 8'h01; // step after the write lands
    if (start) begin
      st_d = emasr_pkg::ST_RX; bit_d = 4'h0; byte_d = 2'h0; drv_d = 1'b0;
    end else if (stop) begin
      st_d = emasr_pkg::ST_IDLE; drv_d = 1'b0;
    end else begin
      case (st_q)
        emasr_pkg::ST_RX: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            bit_d = bit_q + 4'h1;
          end else if (fall && bit_q == emasr_pkg::BITS_PER_BYTE) begin
            st_d = emasr_pkg::ST_ACK; drv_d = 1'b1;
            if (byte_q == 2'h0) begin
              rnw_d = sh_q[0];
              if (sh_q[7:1] != emasr_pkg::DEV_ADDR_DEF) begin
                st_d = emasr_pkg::ST_IDLE; drv_d = 1'b0; // not ours
              end
            end else if (byte_q == 2'h1) begin
              ptr_d = sh_q;
            end else begin
              wr_d = 1'b1; wdat_d = sh_q;
            end
            if (byte_q != 2'h2) byte_d = byte_q + 2'h1;
          end
        end
        emasr_pkg::ST_ACK: begin
          if (fall) begin
            bit_d = 4'h0;
            if (rnw_q) load = 1'b1;
            else begin
              st_d = emasr_pkg::ST_RX; drv_d = 1'b0;
            end
          end
        end
        emasr_pkg::ST_TX: begin
          if (fall) begin
            if (bit_q == 4'h7) begin
              st_d = emasr_pkg::ST_RACK; drv_d = 1'b0;
            end else begin
              bit_d = bit_q + 4'h1;
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
            end
          end
        end
        emasr_pkg::ST_RACK: begin
          if (rise) nack_d = sda_s_q;
          else if (fall) begin
            bit_d = 4'h0;
            if (nack_q) st_d = emasr_pkg::ST_IDLE;
            else load = 1'b1;
          end
        end
        default: st_d = emasr_pkg::ST_IDLE;
      endcase
    end
    // fetch next read byte, then step the pointer
    if (load) begin
      st_d = emasr_pkg::ST_TX; sh_d = regs.rdata;
      drv_d = ~regs.rdata[7]; ptr_d = ptr_q + 8'h01;
    end
    oe_n_d = ~drv_d; // pin enable is active low, kept in its own flop
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= emasr_pkg::ST_IDLE; sh_q <= 8'h00; ptr_q <= 8'h00;
      wdat_q <= 8'h00; bit_q <= 4'h0; byte_q <= 2'h0; rnw_q <= 1'b0;
      nack_q <= 1'b0; drv_q <= 1'b0; wr_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d; sh_q <= sh_d; ptr_q <= ptr_d; wdat_q <= wdat_d;
      bit_q <= bit_d; byte_q <= byte_d; rnw_q <= rnw_d;
      nack_q <= nack_d; drv_q <= drv_d; wr_q <= wr_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign regs.wr_stb = wr_q;
  assign regs.addr   = ptr_q;
  assign regs.wdata  = wdat_q;
  assign sda_oe_n_o  = oe_n_q; // open drain: low enable pulls sda low
endmodule // emasr_serial
`default_nettype wire

/* File: rtl/emasr_top.sv */
// energy meter, alert enables and snapshot control register bank
// What this block does
// - pair over/under alert enables at 0x1A
// - io pair alert enables in same register
// - 48-bit energy accumulator, bytes 0x7A up
// - 32-bit tick counter counts accumulation cycles
// - meter reset bit holds both cleared
// - meter halt bit freezes both values
// - tick wrap sets tick overflow flag
// - energy wrap sets energy overflow flag
// - alert flag latched, host write clears
// - read-only nvm lock status bit
// - reserved bits read zero, writes ignored
// - four-bit snapshot input select field
// - adc halt bit enters snapshot mode
`timescale 1ns/100ps
`default_nettype none
module emasr_top (
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         scl_i,
  input  wire logic                         sda_i,
  output logic                              sda_o,
  output logic                              sda_oe_n_o,
  input  wire logic                         conv_done_i,
  input  wire logic [emasr_pkg::POWER_W-1:0] power_i,
  input  wire logic                         alert_evt_i,
  input  wire logic                         nvm_factory_locked_i,
  input  wire logic [emasr_pkg::SNAP_W-1:0]  snap_data_i,
  output logic [7:0]                        alert_en_o,
  output logic                              snapshot_mode_o,
  output logic [3:0]                        snapshot_sel_o,
  output logic [emasr_pkg::SNAP_W-1:0]      snap_result_o,
  output logic                              snap_valid_o
);
  emasr_reg_if rif ();
  logic [7:0]                    alen_q, alen_d;
  logic [emasr_pkg::ENERGY_W-1:0] energy_q, energy_d;
  logic [emasr_pkg::TICK_W-1:0]   tick_q, tick_d;
  logic [emasr_pkg::ENERGY_W:0]   sum_e;
  logic [emasr_pkg::TICK_W:0]     sum_t;
  logic mrst_q, mrst_d, mhalt_q, mhalt_d, tovf_q, tovf_d;
  logic eovf_q, eovf_d, agen_q, agen_d, ahalt_q, ahalt_d, sval_q, sval_d;
  logic [3:0]                    sel_q, sel_d;
  logic [emasr_pkg::SNAP_W-1:0]  sres_q, sres_d;
  logic acc, wr_ctl, wr_snap, wr_meter;
  logic [7:0] e_idx, t_idx, rd;

  emasr_serial u_serial (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_oe_n_o (sda_oe_n_o),
    .regs       (rif.bus)
  );

  // decode shared by read mux and write path
  assign e_idx   = rif.addr - emasr_pkg::ENERGY_OFF;
  assign t_idx   = rif.addr - emasr_pkg::TICK_OFF;
  assign wr_ctl  = rif.wr_stb && rif.addr == emasr_pkg::METER_CTL_OFF;
  assign wr_snap = rif.wr_stb && rif.addr == emasr_pkg::SNAP_CTL_OFF;
  assign wr_meter = rif.wr_stb && (emasr_pkg::in_span(rif.addr,
      emasr_pkg::ENERGY_OFF, emasr_pkg::ENERGY_BYTES) ||
      emasr_pkg::in_span(rif.addr, emasr_pkg::TICK_OFF,
      emasr_pkg::TICK_BYTES));
  assign acc   = conv_done_i & ~mrst_q & ~mhalt_q;
  assign sum_e = {1'b0, energy_q} + (emasr_pkg::ENERGY_W+1)'(power_i);
  assign sum_t = {1'b0, tick_q} + 33'h0_0000_0001;

  // read mux; most significant byte at the lowest address
  // multi-byte reads are not atomic; halt the meter for a clean value
  always_comb begin
    rd = 8'h00; // unmapped and reserved read as zero
    if (rif.addr == emasr_pkg::ALERT_EN_OFF) rd = alen_q;
    else if (emasr_pkg::in_span(rif.addr, emasr_pkg::ENERGY_OFF,
                                emasr_pkg::ENERGY_BYTES))
      rd = energy_q[8*(5-int'(e_idx)) +: 8];
    else if (emasr_pkg::in_span(rif.addr, emasr_pkg::TICK_OFF,
                                emasr_pkg::TICK_BYTES))
      rd = tick_q[8*(3-int'(t_idx)) +: 8];
    else if (rif.addr == emasr_pkg::METER_CTL_OFF)
      rd = {mrst_q, mhalt_q, tovf_q, eovf_q, agen_q,
            nvm_factory_locked_i, 2'b00};
    else if (rif.addr == emasr_pkg::SNAP_CTL_OFF)
      rd = {sel_q, ahalt_q, 3'b000};
  end
  assign rif.rdata = rd;

  // next state of the bank; reset hold applied last so it always wins
  always_comb begin
    alen_d = alen_q; energy_d = energy_q; tick_d = tick_q;
    mrst_d = mrst_q; mhalt_d = mhalt_q; tovf_d = tovf_q; eovf_d = eovf_q;
    agen_d = agen_q; sel_d = sel_q; ahalt_d = ahalt_q;
    sres_d = sres_q; sval_d = sval_q;
    if (acc) begin
      energy_d = sum_e[emasr_pkg::ENERGY_W-1:0];
      tick_d   = sum_t[emasr_pkg::TICK_W-1:0];
    end
    if (rif.wr_stb) begin
      if (rif.addr == emasr_pkg::ALERT_EN_OFF)
        alen_d = rif.wdata;
      if (emasr_pkg::in_span(rif.addr, emasr_pkg::ENERGY_OFF,
                             emasr_pkg::ENERGY_BYTES))
        energy_d[8*(5-int'(e_idx)) +: 8] = rif.wdata;
      if (emasr_pkg::in_span(rif.addr, emasr_pkg::TICK_OFF,
                             emasr_pkg::TICK_BYTES))
        tick_d[8*(3-int'(t_idx)) +: 8] = rif.wdata;
    end
    if (wr_ctl) begin // lock and low bits are not stored
      mrst_d  = rif.wdata[emasr_pkg::MC_RESET_BIT];
      mhalt_d = rif.wdata[emasr_pkg::MC_HALT_BIT];
      tovf_d  = rif.wdata[emasr_pkg::MC_TOVF_BIT];
      eovf_d  = rif.wdata[emasr_pkg::MC_EOVF_BIT];
      agen_d  = rif.wdata[emasr_pkg::MC_ALERT_BIT];
    end
    // hardware set wins over a same-cycle host clear
    if (acc && sum_t[emasr_pkg::TICK_W]) tovf_d = 1'b1;
    if (acc && sum_e[emasr_pkg::ENERGY_W]) eovf_d = 1'b1;
    if (alert_evt_i) agen_d = 1'b1;
    if (mrst_q) begin
      energy_d = emasr_pkg::ENERGY_RST;
      tick_d   = emasr_pkg::TICK_RST;
    end
    // snapshot capture; result dropped when selection or mode changes
    // capture first, so a same-cycle write that moves the select voids it
    if (ahalt_q && conv_done_i) begin
      sres_d = snap_data_i;
      sval_d = 1'b1;
    end
    if (wr_snap) begin
      sel_d   = rif.wdata[7:emasr_pkg::SC_SEL_LSB];
      ahalt_d = rif.wdata[emasr_pkg::SC_HALT_BIT];
      if (sel_d != sel_q || !ahalt_d) sval_d = 1'b0;
    end
    if (!ahalt_q) sval_d = 1'b0;
  end

  // register stage only; every decision sits in the block above
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alen_q <= emasr_pkg::ALERT_EN_RST; energy_q <= emasr_pkg::ENERGY_RST;
      tick_q <= emasr_pkg::TICK_RST; mrst_q <= 1'b0; mhalt_q <= 1'b0;
      tovf_q <= 1'b0; eovf_q <= 1'b0; agen_q <= 1'b0;
      sel_q <= emasr_pkg::SNAP_SEL_RST; ahalt_q <= 1'b0;
      sres_q <= 16'h0000; sval_q <= 1'b0;
    end else begin
      alen_q <= alen_d; energy_q <= energy_d; tick_q <= tick_d;
      mrst_q <= mrst_d; mhalt_q <= mhalt_d; tovf_q <= tovf_d;
      eovf_q <= eovf_d; agen_q <= agen_d; sel_q <= sel_d;
      ahalt_q <= ahalt_d; sres_q <= sres_d; sval_q <= sval_d;
    end
  end

  // the pin only ever pulls low; the enable carries the data
  assign sda_o           = 1'b0;
  assign alert_en_o      = alen_q;
  assign snapshot_mode_o = ahalt_q; // adc stops sequencing
  assign snapshot_sel_o  = sel_q;
  assign snap_result_o   = sres_q;
  assign snap_valid_o    = sval_q;

  // checks
  // all on the one clock and asleep while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // a register write shows on the outputs one clock after the strobe
  alert_en_wr_a: assert property (
    rif.wr_stb && rif.addr == emasr_pkg::ALERT_EN_OFF
    |=> alert_en_o == $past(rif.wdata)) else $error("alert enable lost");

  // meter hold, freeze and wrap
  meter_reset_hold_a: assert property (
    mrst_q |=> energy_q == '0 && tick_q == '0)
    else $error("meter not held clear");
  meter_halt_freeze_a: assert property (
    mhalt_q && !mrst_q && !wr_meter |=> $stable(energy_q) && $stable(tick_q))
    else $error("halted meter moved");
  tick_wrap_a: assert property (
    acc && !wr_meter && tick_q == '1 |=> tovf_q && tick_q == '0)
    else $error("tick wrap missed");
  energy_wrap_a: assert property (
    acc && sum_e[emasr_pkg::ENERGY_W] |=> eovf_q)
    else $error("energy wrap missed");
  // an alert sets the flag even against a same-cycle host clear
  alert_latch_a: assert property (
    alert_evt_i |=> agen_q) else $error("alert flag not set");
  alert_keep_a: assert property (
    agen_q && !wr_ctl |=> agen_q) else $error("alert flag cleared");
  tick_flag_keep_a: assert property (
    tovf_q && !wr_ctl |=> tovf_q) else $error("tick flag dropped");
  energy_flag_keep_a: assert property (
    eovf_q && !wr_ctl |=> eovf_q) else $error("energy flag dropped");

  // read side: lock mirrors its pin, reserved bits stay zero; then tick and energy step checks
  ctl_read_a: assert property (
    rif.addr == emasr_pkg::METER_CTL_OFF
    |-> rd[2] == nvm_factory_locked_i && rd[1:0] == 2'b00)
    else $error("control read wrong");
  snap_read_a: assert property (
    rif.addr == emasr_pkg::SNAP_CTL_OFF |-> rd[2:0] == 3'b000)
    else $error("snapshot reserved bits set");
  tick_step_a: assert property (
    acc && !wr_meter && tick_q != '1 |=> tick_q == $past(tick_q) + 1)
    else $error("tick did not step");
  energy_step_a: assert property (
    acc && !wr_meter && !sum_e[emasr_pkg::ENERGY_W]
    |=> energy_q == $past(energy_q) + 48'($past(power_i)))
    else $error("energy did not add");

  // snapshot path
  snap_capture_a: assert property (
    ahalt_q && conv_done_i && !wr_snap
    |=> snap_valid_o && snap_result_o == $past(snap_data_i))
    else $error("snapshot not captured");
  snap_drop_a: assert property (
    !ahalt_q |=> !snap_valid_o) else $error("stale snapshot kept");
  snap_write_a: assert property (
    wr_snap |=> snapshot_sel_o == $past(rif.wdata[7:emasr_pkg::SC_SEL_LSB])
    && snapshot_mode_o == $past(rif.wdata[emasr_pkg::SC_HALT_BIT]))
    else $error("snapshot control lost");

  // main scenarios
  acc_seen_c: cover property (acc ##1 acc);
  reset_seen_c: cover property (wr_ctl ##1 mrst_q);
  snap_seen_c: cover property (wr_snap ##[1:20] snap_valid_o);
  wrap_seen_c: cover property (acc && sum_e[emasr_pkg::ENERGY_W]);
  alert_seen_c: cover property (alert_evt_i ##1 agen_q);
endmodule // emasr_top
`default_nettype wire

/* File: bench/emasr_host.sv */
// two-wire serial host model driving the register bank pins
`timescale 1ns/100ps
`default_nettype none
module emasr_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // open drain: 1 releases the line to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // one bit; data moves only while scl is low, well past the answer
  task automatic bit_x(input logic b, output logic s);
    sda_o <= b;
    repeat (6) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    s = sda_i;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // a = 1 gives start (or repeated start), a = 0 gives stop
  task automatic edge_c(input logic a);
    sda_o <= a;
    repeat (6) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    sda_o <= ~a;
    repeat (8) @(posedge clk_i);
    if (a) begin
      scl_o <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(m_ack, ack);
    ack = ~ack;
  endtask

  // pointer then data; the only path that clears the alert flag
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d[$], output logic ok);
    logic [7:0] q;
    logic       k;
    edge_c(1'b1);
    byte_x({a, 1'b0}, 1'b1, q, ok);
    byte_x(p, 1'b1, q, k);
    ok = ok & k;
    foreach (d[i]) begin
      byte_x(d[i], 1'b1, q, k);
      ok = ok & k;
    end
    edge_c(1'b0);
  endtask

  // pointer, repeated start, n bytes; last one refused to end the read
  task automatic rd(input logic [7:0] p, input int n,
                    output logic [47:0] v);
    logic [7:0] q;
    logic       k;
    v = '0;
    edge_c(1'b1);
    byte_x({emasr_pkg::DEV_ADDR_DEF, 1'b0}, 1'b1, q, k);
    byte_x(p, 1'b1, q, k);
    edge_c(1'b1);
    byte_x({emasr_pkg::DEV_ADDR_DEF, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      byte_x(8'hFF, (i == n - 1), q, k);
      v = {v[39:0], q};
    end
    edge_c(1'b0);
  endtask
endmodule // emasr_host
`default_nettype wire

/* File: bench/emasr_top_tb.sv */
// self-checking bench for the meter register bank
`timescale 1ns/100ps
`default_nettype none
module emasr_top_tb;
  logic        clk       = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        conv_done = 1'b0;
  logic [23:0] power     = 24'h000000;
  logic        alert     = 1'b0;
  logic        lock      = 1'b1;
  logic [15:0] snap      = 16'h0000;
  logic        scl;
  logic        sda_h;
  logic        sda_o;
  logic        sda_oe_n;
  logic [7:0]  alert_en;
  logic        smode;
  logic [3:0]  ssel;
  logic [15:0] sres;
  logic        svalid;
  logic        ok;
  int          error_cnt = 0;
  int          samples_checked = 0;
  wire logic   sda_w;

  // pull-up line: low when either side pulls
  assign sda_w = sda_h & (sda_oe_n | sda_o);
  always #20 clk = ~clk;

  emasr_top emasr_top_i (
    .clk_i(clk), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .conv_done_i(conv_done),
    .power_i(power), .alert_evt_i(alert), .nvm_factory_locked_i(lock),
    .snap_data_i(snap), .alert_en_o(alert_en), .snapshot_mode_o(smode),
    .snapshot_sel_o(ssel), .snap_result_o(sres), .snap_valid_o(svalid)
  );
  emasr_host emasr_host_i (
    .clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h)
  );

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic w(input logic [7:0] p, input logic [7:0] d[$]);
    emasr_host_i.wr(emasr_pkg::DEV_ADDR_DEF, p, d, ok);
    chk("ack", 48'h1, 48'(ok));
  endtask

  task automatic rc(input string nm, input logic [7:0] p, input int n,
                    input logic [47:0] e);
    logic [47:0] v;
    emasr_host_i.rd(p, n, v);
    chk(nm, e, v);
  endtask

  // one conversion-done pulse with its results
  task automatic conv(input logic [23:0] p, input logic [15:0] s);
    @(posedge clk);
    conv_done <= 1'b1;
    power <= p;
    snap <= s;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // hang guard: all waits are fixed, this only catches runaways
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    $display("ERROR watchdog expected done seen running");
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk);
    // values after reset
    rc("alert_en", 8'h1A, 1, 48'h0);
    rc("energy", 8'h7A, 6, 48'h0);
    rc("tick", 8'h80, 4, 48'h0);
    rc("meter_ctl", 8'h84, 1, 48'h04);
    rc("snap_ctl", 8'h85, 1, 48'h0);
    // walking one through the enables, then a foreign address
    for (int i = 0; i < 8; i++) begin
      w(8'h1A, {8'(1 << i)});
      chk("alert_en_o", 48'(1 << i), 48'(alert_en));
    end
    emasr_host_i.wr(7'h2B, 8'h1A, {8'hFF}, ok);
    chk("foreign_ack", 48'h0, 48'(ok));
    rc("alert_en", 8'h1A, 1, 48'h80);
    // accumulation, then halt, then resume
    repeat (3) conv(24'h000100, 16'h0);
    rc("energy", 8'h7A, 6, 48'h300);
    rc("tick", 8'h80, 4, 48'h3);
    w(8'h84, {8'h40});
    conv(24'h000100, 16'h0);
    rc("energy", 8'h7A, 10, 48'h0300_0000_0003);
    w(8'h84, {8'h00});
    conv(24'h000010, 16'h0);
    rc("energy", 8'h7A, 10, 48'h0310_0000_0004);
    // meter reset holds both cleared until written back
    w(8'h84, {8'h80});
    conv(24'h000100, 16'h0);
    rc("energy", 8'h7A, 6, 48'h0);
    rc("tick", 8'h80, 4, 48'h0);
    w(8'h84, {8'h00});
    conv(24'h000005, 16'h0);
    rc("energy", 8'h7A, 10, 48'h0005_0000_0001);
    // energy wrap alone, then tick wrap alone
    w(8'h7A, {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
              8'h00, 8'h00, 8'h00, 8'h05});
    conv(24'h000001, 16'h0);
    rc("energy", 8'h7A, 6, 48'h0);
    rc("meter_ctl", 8'h84, 1, 48'h14);
    w(8'h84, {8'h00});
    w(8'h80, {8'hFF, 8'hFF, 8'hFF, 8'hFF});
    conv(24'h000002, 16'h0);
    rc("tick", 8'h80, 4, 48'h0);
    rc("meter_ctl", 8'h84, 1, 48'h24);
    // alert latch; lock and reserved bits shrug off writes
    w(8'h84, {8'h00});
    @(posedge clk);
    alert <= 1'b1;
    @(posedge clk);
    alert <= 1'b0;
    rc("meter_ctl", 8'h84, 1, 48'h0C);
    lock <= 1'b0;
    w(8'h84, {8'h07});
    rc("meter_ctl", 8'h84, 1, 48'h00);
    // every select code, each captured in snapshot mode
    for (int c = 0; c < 16; c++) begin
      w(8'h85, {8'(c * 16 + 15)});
      chk("snap_sel", 48'(c), 48'(ssel));
      chk("snap_mode", 48'h1, 48'(smode));
      chk("snap_valid", 48'h0, 48'(svalid));
      conv(24'h0, 16'(16'hC000 + c));
      chk("snap_res", 48'(16'hC000 + c), 48'(sres));
      chk("snap_valid", 48'h1, 48'(svalid));
      rc("snap_ctl", 8'h85, 1, 48'(c * 16 + 8));
    end
    w(8'h85, {8'h00});
    chk("snap_mode", 48'h0, 48'(smode));
    chk("snap_valid", 48'h0, 48'(svalid));
    close_out();
  end
endmodule // emasr_top_tb
`default_nettype wire
